// File: pkg/tmrc_pkg.sv
// Package for the timer one control register block
package tmrc_pkg;
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_WMASK    = 16'hA376;
  // Field positions in the control word
  localparam int          BIT_RUN       = 15;
  localparam int          BIT_IDLE_HALT = 13;
  localparam int          BIT_EXT_SRC   = 8;
  localparam int          BIT_GATE      = 6;
  localparam int          BIT_PRESC     = 4;
  localparam int          BIT_SYNC      = 2;
  localparam int          BIT_TCS       = 1;
  // Prescaler terminal counts: divide by 1, 8, 64, 256
  localparam logic [7:0]  PRESC_TC_1    = 8'h00;
  localparam logic [7:0]  PRESC_TC_8    = 8'h07;
  localparam logic [7:0]  PRESC_TC_64   = 8'h3F;
  localparam logic [7:0]  PRESC_TC_256  = 8'hFF;

  typedef enum logic [1:0] {
    TMRC_SRC_EXT  = 2'b00,
    TMRC_SRC_SECONDARY_OSC_CLOCK = 2'b01,
    TMRC_SRC_LOW_POWER_RC_CLOCK = 2'b10,
    TMRC_SRC_RSVD = 2'b11
  } tmrc_src_t;

  typedef enum logic [1:0] {
    TMRC_DIV_1   = 2'b00,
    TMRC_DIV_8   = 2'b01,
    TMRC_DIV_64  = 2'b10,
    TMRC_DIV_256 = 2'b11
  } tmrc_div_t;

  typedef struct packed {
    logic      timer_run_enable;
    logic      idle_halt_select;
    tmrc_src_t extended_source_select;
    logic      gate_accumulate_enable;
    tmrc_div_t input_prescale_select;
    logic      external_sync_select;
    logic      count_source_select;
  } tmrc_ctrl_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
  } tmrc_bus_t;
endpackage

// File: rtl/tmrc_control.sv
// Timer one control register, count source selection and gating
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module tmrc_control (
  input  wire logic                        i_mclk,
  input  wire logic                        i_srst,
  input  wire logic [tmrc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [15:0]                 i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [15:0]                 o_rdata,
  input  wire logic                        i_idle_mode,
  input  wire logic                        i_external_count_input,
  input  wire logic                        i_secondary_osc_clock,
  input  wire logic                        i_low_power_rc_clock,
  output logic                             o_count_tick,
  output logic                             o_timer_active
);
  tmrc_pkg::tmrc_bus_t  bus;
  tmrc_pkg::tmrc_ctrl_t ctrl;
  tmrc_pkg::tmrc_ctrl_t next_ctrl;
  logic [15:0] ctrl_word;
  logic [15:0] next_rdata;
  // Pin synchronisers: index 0 pin input, 1 secondary osc, 2 RC osc
  logic [2:0]  pin_meta;
  logic [2:0]  pin_sync;
  logic [2:0]  pin_last;
  logic [2:0]  pin_rise;
  logic        half_rate;
  logic        ext_edge;
  logic        ext_edge_q;
  logic        raw_tick;
  logic        run_ok;
  logic        next_active;

  assign bus = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[tmrc_pkg::BIT_RUN]                    = ctrl.timer_run_enable;
    ctrl_word[tmrc_pkg::BIT_IDLE_HALT]              = ctrl.idle_halt_select;
    ctrl_word[tmrc_pkg::BIT_EXT_SRC+1:tmrc_pkg::BIT_EXT_SRC] = ctrl.extended_source_select;
    ctrl_word[tmrc_pkg::BIT_GATE]                   = ctrl.gate_accumulate_enable;
    ctrl_word[tmrc_pkg::BIT_PRESC+1:tmrc_pkg::BIT_PRESC]     = ctrl.input_prescale_select;
    ctrl_word[tmrc_pkg::BIT_SYNC]                   = ctrl.external_sync_select;
    ctrl_word[tmrc_pkg::BIT_TCS]                    = ctrl.count_source_select;
  end

  // Register write and read-back
  always_comb begin
    next_ctrl  = ctrl;
    next_rdata = 16'h0000;
    if (bus.wr && bus.addr == tmrc_pkg::REG_CTRL) begin
      next_ctrl.timer_run_enable       = bus.wdata[tmrc_pkg::BIT_RUN];
      next_ctrl.idle_halt_select       = bus.wdata[tmrc_pkg::BIT_IDLE_HALT];
      next_ctrl.extended_source_select =
        tmrc_pkg::tmrc_src_t'(bus.wdata[tmrc_pkg::BIT_EXT_SRC+1:tmrc_pkg::BIT_EXT_SRC]);
      next_ctrl.gate_accumulate_enable = bus.wdata[tmrc_pkg::BIT_GATE];
      next_ctrl.input_prescale_select  =
        tmrc_pkg::tmrc_div_t'(bus.wdata[tmrc_pkg::BIT_PRESC+1:tmrc_pkg::BIT_PRESC]);
      next_ctrl.external_sync_select   = bus.wdata[tmrc_pkg::BIT_SYNC];
      next_ctrl.count_source_select    = bus.wdata[tmrc_pkg::BIT_TCS];
    end
    if (bus.rd && bus.addr == tmrc_pkg::REG_CTRL) begin
      next_rdata = ctrl_word & tmrc_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctrl    <= tmrc_pkg::tmrc_ctrl_t'(9'h000);
      o_rdata <= 16'h0000;
    end else begin
      ctrl    <= next_ctrl;
      o_rdata <= next_rdata;
    end
  end

  // Source selection and gating
  always_comb begin
    pin_rise = pin_sync & ~pin_last;
    run_ok   = ctrl.timer_run_enable && !(i_idle_mode && ctrl.idle_halt_select);
    unique case (ctrl.extended_source_select)
      tmrc_pkg::TMRC_SRC_EXT:  ext_edge = pin_rise[0];
      tmrc_pkg::TMRC_SRC_SECONDARY_OSC_CLOCK: ext_edge = pin_rise[1];
      tmrc_pkg::TMRC_SRC_LOW_POWER_RC_CLOCK: ext_edge = pin_rise[2];
      tmrc_pkg::TMRC_SRC_RSVD: ext_edge = 1'b0;
    endcase
    if (!ctrl.count_source_select) begin
      // Gated accumulation counts half-rate ticks while the pin is high
      raw_tick = half_rate && (!ctrl.gate_accumulate_enable || pin_sync[0]);
    end else if (ctrl.external_sync_select) begin
      // Resynchronised edge lands one cycle later, on a fresh clock edge
      raw_tick = ext_edge_q;
    end else begin
      raw_tick = ext_edge;
    end
    next_active = run_ok;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pin_meta       <= 3'h0;
      pin_sync       <= 3'h0;
      pin_last       <= 3'h0;
      half_rate      <= 1'b0;
      ext_edge_q     <= 1'b0;
      o_timer_active <= 1'b0;
    end else begin
      pin_meta       <= {i_low_power_rc_clock, i_secondary_osc_clock, i_external_count_input};
      pin_sync       <= pin_meta;
      pin_last       <= pin_sync;
      half_rate      <= !half_rate;
      ext_edge_q     <= ext_edge;
      o_timer_active <= next_active;
    end
  end

  tmrc_prescale u_prescale (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_clear (!run_ok),
    .i_tick  (raw_tick && run_ok),
    .i_sel   (ctrl.input_prescale_select),
    .o_tick  (o_count_tick)
  );

  sequence s_ctrl_read;
    i_rd && i_addr == tmrc_pkg::REG_CTRL;
  endsequence

  a_read_unimpl_zero : assert property (@(posedge i_mclk) disable iff (i_srst)
    s_ctrl_read |=> (o_rdata & ~tmrc_pkg::CTRL_WMASK) == 16'h0000)
    else $error("Unimplemented bit read as one");
  a_read_run_bit : assert property (@(posedge i_mclk) disable iff (i_srst)
    s_ctrl_read |=> o_rdata[tmrc_pkg::BIT_RUN] == $past(ctrl.timer_run_enable))
    else $error("Run bit read back wrong");
  a_write_then_read : assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_wr && i_addr == tmrc_pkg::REG_CTRL) ##1 s_ctrl_read
      |=> o_rdata == ($past(i_wdata, 2) & tmrc_pkg::CTRL_WMASK))
    else $error("Written word not read back");
  a_stop_no_tick : assert property (@(posedge i_mclk) disable iff (i_srst)
    (!ctrl.timer_run_enable)[*2] |-> !o_count_tick)
    else $error("Tick while timer stopped");
  a_idle_halt : assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_idle_mode && ctrl.idle_halt_select)[*2] |-> !o_count_tick && !o_timer_active)
    else $error("Tick while halted in Idle");
  a_idle_keeps_run : assert property (@(posedge i_mclk) disable iff (i_srst)
    (ctrl.timer_run_enable && !ctrl.idle_halt_select) |=> o_timer_active)
    else $error("Timer stopped in Idle without halt");
  a_half_rate : assert property (@(posedge i_mclk) disable iff (i_srst)
    (run_ok && !ctrl.count_source_select && !ctrl.gate_accumulate_enable
      && ctrl.input_prescale_select == tmrc_pkg::TMRC_DIV_1)[*4] |-> o_count_tick != $past(o_count_tick))
    else $error("Internal source not at half rate");
  a_gate_low_hold : assert property (@(posedge i_mclk) disable iff (i_srst)
    (!ctrl.count_source_select && ctrl.gate_accumulate_enable && !pin_sync[0]) |=> !o_count_tick)
    else $error("Gated count while gate low");
  a_reserved_src : assert property (@(posedge i_mclk) disable iff (i_srst)
    (ctrl.count_source_select && ctrl.extended_source_select == tmrc_pkg::TMRC_SRC_RSVD)[*3]
      |-> !o_count_tick)
    else $error("Reserved source produced a tick");
  // Checked at the output so that a lost resync stage or prescaler slip is caught
  a_sync_delay : assert property (@(posedge i_mclk) disable iff (i_srst)
    (run_ok && ctrl.count_source_select && ctrl.external_sync_select
      && ctrl.input_prescale_select == tmrc_pkg::TMRC_DIV_1)[*3] |-> o_count_tick == $past(ext_edge, 2))
    else $error("Synchronised edge not delayed one cycle");
endmodule // tmrc_control

// File: rtl/tmrc_prescale.sv
// Input clock prescaler for the timer count source
`timescale 1ns/1ps
module tmrc_prescale (
  input  wire logic             i_mclk,
  input  wire logic             i_srst,
  input  wire logic             i_clear,
  input  wire logic             i_tick,
  input  wire tmrc_pkg::tmrc_div_t i_sel,
  output logic                  o_tick
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       next_tick;
  logic [7:0] term;

  always_comb begin
    unique case (i_sel)
      tmrc_pkg::TMRC_DIV_1:   term = tmrc_pkg::PRESC_TC_1;
      tmrc_pkg::TMRC_DIV_8:   term = tmrc_pkg::PRESC_TC_8;
      tmrc_pkg::TMRC_DIV_64:  term = tmrc_pkg::PRESC_TC_64;
      tmrc_pkg::TMRC_DIV_256: term = tmrc_pkg::PRESC_TC_256;
    endcase
    next_count = count;
    next_tick  = 1'b0;
    if (i_clear) begin
      next_count = 8'h00;
    end else if (i_tick) begin
      if (count >= term) begin
        next_count = 8'h00;
        next_tick  = 1'b1;
      end else begin
        next_count = count + 8'h01;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      count  <= 8'h00;
      o_tick <= 1'b0;
    end else begin
      count  <= next_count;
      o_tick <= next_tick;
    end
  end

  a_presc_div_one : assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_sel == tmrc_pkg::TMRC_DIV_1 && i_tick && !i_clear) |=> o_tick)
    else $error("Divide by one did not pass the tick");
  a_presc_clear : assert property (@(posedge i_mclk) disable iff (i_srst)
    i_clear |=> !o_tick)
    else $error("Prescaler ticked while cleared");
endmodule // tmrc_prescale

// File: sim/test_tmrc_control.sv
// Self-checking testbench for the timer one control register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_tmrc_control;
  logic        i_mclk = 0;
  logic        i_srst = 1;
  logic [3:0]  i_addr = 0;
  logic [15:0] i_wdata = 0;
  logic        i_wr = 0;
  logic        i_rd = 0;
  logic        i_idle_mode = 0;
  logic        i_external_count_input = 0;
  logic        i_secondary_osc_clock = 0;
  logic        i_low_power_rc_clock = 0;
  logic [15:0] o_rdata;
  logic        o_count_tick;
  logic        o_timer_active;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          sel = 0;
  logic        pin_lvl = 0;
  logic [2:0]  tg = 0;
  logic [15:0] v;
  int          n;

  tmrc_control u_tmrc_control (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_idle_mode(i_idle_mode),
    .i_external_count_input(i_external_count_input), .i_secondary_osc_clock(i_secondary_osc_clock),
    .i_low_power_rc_clock(i_low_power_rc_clock), .o_count_tick(o_count_tick), .o_timer_active(o_timer_active));

  initial begin
    forever #20 i_mclk = ~i_mclk;
  end

  // Source stimulus: period of 8 cycles keeps each level well above the 2-cycle minimum
  always @(posedge i_mclk) begin
    tg <= tg + 3'h1;
    i_external_count_input <= (sel == 1) ? tg[2] : pin_lvl;
    i_secondary_osc_clock <= (sel == 2) & tg[2];
    i_low_power_rc_clock <= (sel == 3) & tg[2];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_mclk);
  endtask

  // Write then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [15:0] d, output logic [15:0] q);
    i_wr <= 1'b1; i_addr <= 4'h0; i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0; i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 q = o_rdata;
    @(posedge i_mclk);
  endtask

  // Tick count over a window; edges of the window may cut one tick
  task automatic window(input int c, input int e);
    n = 0;
    repeat (c) begin
      @(posedge i_mclk);
      if (o_count_tick === 1'b1) n++;
    end
    cmp_count++;
    if (n < e - 1 || n > e + 1) begin
      n_fail++;
      $display("wrong value tick count expected %0d seen %0d", e, n);
    end
  endtask

  task automatic t_regs();
    rd_reg(4'h0, v); `CHK("ctrl reset", 16'h0000, v)
    wr_reg(4'h0, 16'hFFFF);
    rd_reg(4'h0, v); `CHK("ctrl unimpl", 16'hA376, v)
    wr_reg(4'h3, 16'h0000);
    rd_reg(4'h0, v); `CHK("ctrl kept", 16'hA376, v)
    rd_reg(4'h3, v); `CHK("unmapped", 16'h0000, v)
    wr_rd(16'h5A5A, v); `CHK("back to back", 16'h0252, v)
    wr_reg(4'h0, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_run_presc();
    int div [4] = '{1, 8, 64, 256};
    wr_reg(4'h0, 16'h8000);
    // Status is registered after the write lands, so look one edge later
    @(posedge i_mclk);
    `CHK("active", 1'b1, o_timer_active)
    window(40, 20);
    wr_reg(4'h0, 16'h0000);
    @(posedge i_mclk);
    `CHK("stopped", 1'b0, o_timer_active)
    window(40, 0);
    for (int d = 0; d < 4; d++) begin
      wr_reg(4'h0, 16'h8000 | (16'(d) << 4));
      window(1024, 512 / div[d]);
    end
    $display("test run and prescale done");
  endtask

  task automatic t_idle();
    i_idle_mode <= 1'b1;
    wr_reg(4'h0, 16'hA000);
    @(posedge i_mclk);
    `CHK("idle halted", 1'b0, o_timer_active)
    window(40, 0);
    wr_reg(4'h0, 16'h8000);
    @(posedge i_mclk);
    `CHK("idle runs", 1'b1, o_timer_active)
    window(40, 20);
    i_idle_mode <= 1'b0;
    $display("test idle done");
  endtask

  task automatic t_gate();
    pin_lvl <= 1'b0;
    wr_reg(4'h0, 16'h8040);
    window(40, 0);
    pin_lvl <= 1'b1;
    repeat (4) @(posedge i_mclk);
    window(40, 20);
    pin_lvl <= 1'b0;
    $display("test gate done");
  endtask

  // Gate bit is set throughout: the external path must ignore it
  task automatic t_ext();
    int src [4] = '{1, 2, 3, 1};
    for (int s = 0; s < 4; s++)
      for (int y = 0; y < 2; y++) begin
        sel <= src[s];
        wr_reg(4'h0, 16'h8042 | (16'(s) << 8) | (16'(y) << 2));
        repeat (8) @(posedge i_mclk);
        window(64, (s == 3) ? 0 : 8);
      end
    sel <= 0;
    wr_reg(4'h0, 16'h0000);
    $display("test external done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    `CHK("active reset", 1'b0, o_timer_active)
    t_regs();
    t_run_presc();
    t_idle();
    t_gate();
    t_ext();
    final_report();
  end
endmodule // test_tmrc_control
